// ==== core/udg_pkg.sv ====
// constants, types and helpers shared by the usb device global state block
`default_nettype none
package udg_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFS_FRAME = 8'h00;
	localparam logic [7:0] OFS_STATE = 8'h04;
	localparam logic [7:0] OFS_FADDR = 8'h08;
	localparam logic [7:0] OFS_BYTEVIEW = 8'h0C;
	localparam logic [7:0] OFS_IER = 8'h10;
	localparam logic [7:0] OFS_IDR = 8'h14;
	localparam logic [7:0] OFS_IMR = 8'h18;
	// frame counter register layout
	localparam int unsigned FRAME_W = 11;
	localparam int unsigned SOF_ERROR_FLAG_BIT = 16;
	localparam int unsigned SOF_GOOD_FLAG_BIT = 17;
	// byte-wide view layout: low byte in lanes 0, high byte in lane 1
	localparam int unsigned BV_ERR_BIT = 3;
	localparam int unsigned BV_OK_BIT = 4;
	localparam int unsigned BV_HI_LSB = 8;
	localparam int unsigned BYTE_W = 8;
	// device state control layout
	localparam int unsigned ADDR_BIT = 0;
	localparam int unsigned CFG_BIT = 1;
	localparam int unsigned PERMIT_BIT = 2;
	localparam int unsigned RESUME_BIT = 3;
	localparam int unsigned KDRV_BIT = 4;
	localparam logic PERMIT_RST = 1'h0;
	localparam logic KDRV_RST = 1'h1;
	// function address register layout
	localparam int unsigned FUNCTION_ADDRESS_W = 7;
	localparam int unsigned FEN_BIT = 8;
	localparam logic [6:0] FUNCTION_ADDRESS_RST = 7'h00;
	localparam logic FEN_RST = 1'h1;
	// interrupt mask layout: endpoints 5..0, bus events 8..11 and 13
	localparam int unsigned IRQ_W = 14;
	localparam logic [13:0] IRQ_VALID = 14'h2F3F;
	localparam logic [13:0] IMR_RESET = 14'h1200;
	localparam logic [13:0] IMR_RST = IMR_RESET & IRQ_VALID;
	// device state machine, one-hot
	typedef enum logic [2:0] {
		ST_DEFAULT = 3'h1,
		ST_ADDRESS = 3'h2,
		ST_CONFIG = 3'h4
	} udg_dev_state_t;
	// expand the four byte selects into a bit mask
	function automatic logic [31:0] udg_lane_mask(input logic [3:0] sel);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{sel[i]}};
		end
		return m;
	endfunction : udg_lane_mask
endpackage : udg_pkg
`default_nettype wire

// ==== core/udg_frame.sv ====
// start-of-frame tracker: frame index and frame integrity flags
`default_nettype none
module udg_frame import udg_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// start-of-frame events from the packet decoder
	input wire logic sof_pid_stb,
	input wire logic sof_eop_stb,
	input wire logic sof_crc_err,
	input wire logic [10:0] sof_frame,
	// tracked state
	output logic [10:0] frame_index_q,
	output logic sof_good_flag_q,
	output logic sof_error_flag_q,
	output logic frame_start_irq_q
);
	// frame index refreshed at the end of every start-of-frame packet
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			frame_index_q <= '0;
		end else if (sof_eop_stb) begin
			frame_index_q <= sof_frame;
		end
	end

	// integrity flags: set at packet end, cleared by the next pid
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sof_good_flag_q <= 1'b0;
			sof_error_flag_q <= 1'b0;
		end else if (sof_eop_stb) begin
			sof_error_flag_q <= sof_crc_err;
			sof_good_flag_q <= !sof_crc_err;
		end else if (sof_pid_stb) begin
			sof_error_flag_q <= 1'b0;
			sof_good_flag_q <= 1'b0;
		end
	end

	// status event raised on the pid itself, not waiting for the end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			frame_start_irq_q <= 1'b0;
		end else begin
			frame_start_irq_q <= sof_pid_stb;
		end
	end
endmodule : udg_frame
`default_nettype wire

// ==== core/udg_irq_mask.sv ====
// interrupt mask with set-only and clear-only write ports, and gating
`default_nettype none
module udg_irq_mask import udg_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// mask updates, one-cycle strobes with their bit patterns
	input wire logic set_stb,
	input wire logic clr_stb,
	input wire logic [13:0] wr_bits,
	// pending status from the interrupt status logic
	input wire logic [13:0] irq_status,
	// mask and combined request
	output logic [13:0] mask_q,
	output logic usb_irq_q
);
	// ones set or clear bits, zeros leave them; reserved bits stay zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mask_q <= IMR_RST;
		end else if (set_stb) begin
			mask_q <= mask_q | (wr_bits & IRQ_VALID);
		end else if (clr_stb) begin
			mask_q <= mask_q & ~wr_bits;
		end
	end

	// request only where a pending flag meets an enabled mask bit
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			usb_irq_q <= 1'b0;
		end else begin
			usb_irq_q <= |(irq_status & mask_q);
		end
	end
endmodule : udg_irq_mask
`default_nettype wire

// ==== core/udg_top.sv ====
// usb device port global state and control registers on a wishbone slave
//
// Function
// - frame index from each start-of-frame, read only, refreshed at packet end.
// - error flag set at bad frame packet end, cleared by next frame pid.
// - good flag set at clean frame packet end, cleared by next frame pid.
// - frame start status event raised on the pid, not at packet end.
// - byte view shows good flag at high byte bit 4, error at low bit 3.
// - addressed bit reads address state; writing 1 enters it, 0 ignored.
// - configured bit reports state; write 1 enters, write 0 leaves it.
// - remote wake permit gates wake-up sequence and resume request pin.
// - host resume seen bit reads 1 after host resume during remote wake.
// - k-state driven only when drive bit and wake permit are both one.
// - seven bit function address, read and write, zero after reset.
// - function enable gates data packets both ways; writing 0 disables.
// - enable register write only; ones enable endpoint 0..5 interrupts.
// - ones enable suspend, resume, external resume, frame start, bus wake.
// - interrupt raised only where status flag and mask bit are both set.
// - ones in the disable register clear mask bits, zeros do nothing.
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`default_nettype none
module udg_top import udg_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// events from the usb packet decoder and bus monitor
	input wire logic sof_pid_stb,
	input wire logic sof_eop_stb,
	input wire logic sof_crc_err,
	input wire logic [10:0] sof_frame,
	input wire logic bus_reset_stb,
	input wire logic host_resume_stb,
	// pending interrupt flags from the status logic
	input wire logic [13:0] irq_status,
	// interrupt side
	output logic frame_start_irq_q,
	output logic usb_irq_q,
	// device state towards the serial engine and transceiver
	output logic [6:0] function_address_q,
	output logic function_enable_q,
	output logic addressed_state_q,
	output logic configured_state_q,
	output logic resume_pin_en_q,
	output logic kstate_drive_q
);
	// bus handshake
	logic req;
	logic wr_en;
	logic rd_en;
	logic [31:0] lane_m;
	logic [31:0] wr_val;
	logic [31:0] rd_d;
	// write strobes per register
	logic wr_state;
	logic wr_faddr;
	logic wr_ier;
	logic wr_idr;
	// frame tracker results
	logic [10:0] frame_index;
	logic sof_good_flag;
	logic sof_error_flag;
	// device state and control bits
	udg_dev_state_t state_q;
	udg_dev_state_t state_d;
	logic remote_wake_permit_q;
	logic kstate_drive_enable_q;
	logic host_resume_seen_q;
	logic [13:0] mask;
	// byte views of the frame counter
	logic [7:0] frame_index_low;
	logic [7:0] frame_index_high;

	// a request is taken once; ack follows one cycle later
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_en = req && wb_we_i;
	assign rd_en = req && !wb_we_i;
	assign lane_m = udg_lane_mask(wb_sel_i);
	assign wr_val = wb_dat_i & lane_m;

	// per-register write decode; unmapped offsets fall through unused
	assign wr_state = wr_en && (wb_adr_i == OFS_STATE);
	assign wr_faddr = wr_en && (wb_adr_i == OFS_FADDR);
	assign wr_ier = wr_en && (wb_adr_i == OFS_IER);
	assign wr_idr = wr_en && (wb_adr_i == OFS_IDR);

	// acknowledge every request, mapped or not, for exactly one cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	// start-of-frame tracking
	udg_frame u_frame (
		.ref_clk(ref_clk),
		.rst(rst),
		.sof_pid_stb(sof_pid_stb),
		.sof_eop_stb(sof_eop_stb),
		.sof_crc_err(sof_crc_err),
		.sof_frame(sof_frame),
		.frame_index_q(frame_index),
		.sof_good_flag_q(sof_good_flag),
		.sof_error_flag_q(sof_error_flag),
		.frame_start_irq_q(frame_start_irq_q)
	);

	// interrupt mask with enable and disable ports
	udg_irq_mask u_mask (
		.ref_clk(ref_clk),
		.rst(rst),
		.set_stb(wr_ier),
		.clr_stb(wr_idr),
		.wr_bits(wr_val[IRQ_W-1:0]),
		.irq_status(irq_status),
		.mask_q(mask),
		.usb_irq_q(usb_irq_q)
	);

	// byte-wide arrangement of the frame counter
	always_comb begin
		frame_index_low = frame_index[BYTE_W-1:0];
		frame_index_low[BV_ERR_BIT] = sof_error_flag;
		frame_index_high = '0;
		frame_index_high[FRAME_W-BYTE_W-1:0] = frame_index[FRAME_W-1:BYTE_W];
		frame_index_high[BV_OK_BIT] = sof_good_flag;
	end

	// device state transitions from firmware writes and bus reset
	always_comb begin
		state_d = state_q;
		if (bus_reset_stb) begin
			state_d = ST_DEFAULT;
		end else if (wr_state && lane_m[CFG_BIT]) begin
			if (wr_val[CFG_BIT]) begin
				state_d = ST_CONFIG;
			end else if (state_q == ST_CONFIG) begin
				state_d = ST_ADDRESS;
			end else if (wr_val[ADDR_BIT]) begin
				state_d = ST_ADDRESS;
			end
		end else if (wr_state && wr_val[ADDR_BIT]) begin
			if (state_q == ST_DEFAULT) begin
				state_d = ST_ADDRESS;
			end
		end
	end

	// device state register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_DEFAULT;
		end else begin
			state_q <= state_d;
		end
	end

	// state reported to the serial engine
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			addressed_state_q <= 1'b0;
			configured_state_q <= 1'b0;
		end else begin
			case (state_d)
				ST_DEFAULT: begin
					addressed_state_q <= 1'b0;
					configured_state_q <= 1'b0;
				end
				ST_ADDRESS: begin
					addressed_state_q <= 1'b1;
					configured_state_q <= 1'b0;
				end
				ST_CONFIG: begin
					addressed_state_q <= 1'b1;
					configured_state_q <= 1'b1;
				end
				default: begin
					addressed_state_q <= 1'b0;
					configured_state_q <= 1'b0;
				end
			endcase
		end
	end

	// remote wake permit and k-state drive request bits
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			remote_wake_permit_q <= PERMIT_RST;
			kstate_drive_enable_q <= KDRV_RST;
		end else if (wr_state) begin
			if (lane_m[PERMIT_BIT]) begin
				remote_wake_permit_q <= wr_val[PERMIT_BIT];
			end
			if (lane_m[KDRV_BIT]) begin
				kstate_drive_enable_q <= wr_val[KDRV_BIT];
			end
		end
	end

	// host resume caught while a remote wake is permitted; set beats clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			host_resume_seen_q <= 1'b0;
		end else if (host_resume_stb && remote_wake_permit_q) begin
			host_resume_seen_q <= 1'b1;
		end else if (wr_state && wr_val[RESUME_BIT]) begin
			host_resume_seen_q <= 1'b0;
		end
	end

	// wake-up pins: nothing reaches the bus unless the permit is set
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			resume_pin_en_q <= 1'b0;
			kstate_drive_q <= 1'b0;
		end else begin
			resume_pin_en_q <= remote_wake_permit_q;
			kstate_drive_q <= kstate_drive_enable_q
				&& remote_wake_permit_q;
		end
	end

	// function address; the serial engine's default address is zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			function_address_q <= FUNCTION_ADDRESS_RST;
		end else if (bus_reset_stb) begin
			function_address_q <= FUNCTION_ADDRESS_RST;
		end else if (wr_faddr && lane_m[0]) begin
			function_address_q <= wr_val[FUNCTION_ADDRESS_W-1:0];
		end
	end

	// function enable gates data packets in both directions
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			function_enable_q <= FEN_RST;
		end else if (wr_faddr && lane_m[FEN_BIT]) begin
			function_enable_q <= wr_val[FEN_BIT];
		end
	end

	// read multiplexer; write-only and unmapped offsets read zero
	always_comb begin
		rd_d = '0;
		case (wb_adr_i)
			OFS_FRAME: begin
				rd_d[FRAME_W-1:0] = frame_index;
				rd_d[SOF_ERROR_FLAG_BIT] = sof_error_flag;
				rd_d[SOF_GOOD_FLAG_BIT] = sof_good_flag;
			end
			OFS_BYTEVIEW: begin
				rd_d[BYTE_W-1:0] = frame_index_low;
				rd_d[BV_HI_LSB +: BYTE_W] = frame_index_high;
			end
			OFS_STATE: begin
				rd_d[ADDR_BIT] = addressed_state_q;
				rd_d[CFG_BIT] = configured_state_q;
				rd_d[PERMIT_BIT] = remote_wake_permit_q;
				rd_d[RESUME_BIT] = host_resume_seen_q;
				rd_d[KDRV_BIT] = kstate_drive_enable_q;
			end
			OFS_FADDR: begin
				rd_d[FUNCTION_ADDRESS_W-1:0] = function_address_q;
				rd_d[FEN_BIT] = function_enable_q;
			end
			OFS_IMR: begin
				rd_d[IRQ_W-1:0] = mask;
			end
			default: begin
				rd_d = '0;
			end
		endcase
	end

	// read data captured with the request, held until the next read
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wb_dat_o <= '0;
		end else if (rd_en) begin
			wb_dat_o <= rd_d;
		end
	end
endmodule : udg_top
`default_nettype wire

// ==== testbench/udg_props.sv ====
// checker for the usb device global state block, bound to its top
`default_nettype none
module udg_props import udg_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	// usb events and status
	input wire logic sof_pid_stb,
	input wire logic bus_reset_stb,
	input wire logic [13:0] irq_status,
	// device state outputs
	input wire logic frame_start_irq_q,
	input wire logic usb_irq_q,
	input wire logic [6:0] function_address_q,
	input wire logic function_enable_q,
	input wire logic addressed_state_q,
	input wire logic configured_state_q,
	input wire logic resume_pin_en_q,
	input wire logic kstate_drive_q
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// a request the slave takes, and a write to one register
	sequence take_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence wr_s(logic [7:0] a);
		wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == a;
	endsequence
	// bus handshake: one ack, one cycle after taking
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held past one cycle");
	ack_next_a: assert property (take_s |=> wb_ack_o)
		else $error("ack missing after request");
	sof_event_a: assert property (frame_start_irq_q == $past(sof_pid_stb))
		else $error("frame start event not on pid");
	kstate_gate_a: assert property (kstate_drive_q |-> resume_pin_en_q)
		else $error("k-state driven without wake permit");
	bus_rst_a: assert property (bus_reset_stb |=> !addressed_state_q &&
		!configured_state_q && function_address_q == 7'h00)
		else $error("bus reset left state or address");
	addr_hold_a: assert property ($fell(addressed_state_q) |->
		$past(bus_reset_stb)) else $error("address state left without reset");
	faddr_wr_a: assert property (wr_s(OFS_FADDR) ##0 wb_sel_i[0] |=>
		function_address_q == $past(wb_dat_i[6:0]))
		else $error("function address not written");
	fen_wr_a: assert property (wr_s(OFS_FADDR) ##0 wb_sel_i[1] |=>
		function_enable_q == $past(wb_dat_i[8]))
		else $error("function enable not written");
	cfg_wr_a: assert property (wr_s(OFS_STATE) ##0 wb_sel_i[0] |=>
		configured_state_q == $past(wb_dat_i[1]))
		else $error("configured state not written");
	irq_gate_a: assert property (usb_irq_q |-> $past(|irq_status))
		else $error("interrupt without pending flag");
endmodule : udg_props
bind udg_top udg_props u_props (.*);
`default_nettype wire

// ==== testbench/udg_host_model.sv ====
// usb host stand-in: start-of-frame, bus reset and resume events
`default_nettype none
module udg_host_model (
	// clock
	input wire logic ref_clk,
	// decoder events seen by the block
	output logic sof_pid_stb,
	output logic sof_eop_stb,
	output logic sof_crc_err,
	output logic [10:0] sof_frame,
	output logic bus_reset_stb,
	output logic host_resume_stb
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle bus; frame lines carry junk outside end of packet
	initial begin
		sof_pid_stb = 1'b0;
		sof_eop_stb = 1'b0;
		sof_crc_err = 1'b1;
		sof_frame = 11'h555;
		bus_reset_stb = 1'b0;
		host_resume_stb = 1'b0;
	end
	// start-of-frame pid seen
	task sof_pid();
		@(posedge ref_clk) sof_pid_stb <= 1'b1;
		@(posedge ref_clk) sof_pid_stb <= 1'b0;
	endtask : sof_pid
	// end of frame packet, frame number and crc verdict valid only here
	task sof_end(input logic [10:0] f, input logic e);
		repeat (2) @(posedge ref_clk);
		sof_eop_stb <= 1'b1;
		sof_frame <= f;
		sof_crc_err <= e;
		@(posedge ref_clk) sof_eop_stb <= 1'b0;
		sof_frame <= ~f;
		sof_crc_err <= ~e;
	endtask : sof_end
	// host bus reset and host resume
	task bus_reset();
		@(posedge ref_clk) bus_reset_stb <= 1'b1;
		@(posedge ref_clk) bus_reset_stb <= 1'b0;
	endtask : bus_reset
	task resume();
		@(posedge ref_clk) host_resume_stb <= 1'b1;
		@(posedge ref_clk) host_resume_stb <= 1'b0;
	endtask : resume
endmodule : udg_host_model
`default_nettype wire

// ==== testbench/usb_device_global_state_regs_tb_top.sv ====
// self-checking bench for the usb device global state registers
`default_nettype none
module usb_device_global_state_regs_tb_top import udg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic sof_pid_stb, sof_eop_stb, sof_crc_err, bus_reset_stb;
	logic host_resume_stb, frame_start_irq_q, usb_irq_q;
	logic [10:0] sof_frame;
	logic [13:0] irq_status;
	logic [6:0] function_address_q;
	logic function_enable_q, addressed_state_q, configured_state_q;
	logic resume_pin_en_q, kstate_drive_q;
	int errors, total_checks, cycles;
	udg_top dut (.*);
	udg_host_model host (.*);
	// clock and hang guard
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			give_verdict();
		end
	end
	task give_verdict();
		$display("checks %0d, errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : give_verdict
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// one classic cycle, held until ack is sampled
	task xfer(input logic [7:0] a, input logic w, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : xfer
	task wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hF);
		logic [31:0] q;
		xfer(a, 1'b1, s, d, q);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(a, 1'b0, 4'hF, 32'h0, q);
		chk(q, e);
	endtask : rd
	task t_reset();
		@(posedge ref_clk) rst <= 1'b1;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		rd(OFS_FRAME, 32'h0);
		rd(OFS_STATE, 32'h00000010);
		rd(OFS_FADDR, 32'h00000100);
		rd(OFS_IMR, 32'h00000200);
		rd(OFS_IER, 32'h0);
		chk(32'(kstate_drive_q), 32'h0);
	endtask : t_reset
	task t_frame();
		host.sof_pid();
		host.sof_end(11'h7A5, 1'b0);
		rd(OFS_FRAME, 32'h000207A5);
		rd(OFS_BYTEVIEW, 32'h000017A5);
		host.sof_pid();
		rd(OFS_FRAME, 32'h000007A5);
		host.sof_end(11'h3F0, 1'b1);
		rd(OFS_FRAME, 32'h000103F0);
		rd(OFS_BYTEVIEW, 32'h000003F8);
		wr(OFS_FRAME, 32'hFFFFFFFF);
		rd(OFS_FRAME, 32'h000103F0);
	endtask : t_frame
	task t_faddr();
		wr(OFS_FADDR, 32'h0000007F);
		rd(OFS_FADDR, 32'h0000007F);
		chk(32'(function_enable_q), 32'h0);
		wr(OFS_FADDR, 32'hFFFFFF00, 4'h1);
		rd(OFS_FADDR, 32'h0);
		wr(OFS_FADDR, 32'hFFFFFFFF);
		rd(OFS_FADDR, 32'h0000017F);
	endtask : t_faddr
	task t_state();
		wr(OFS_FADDR, 32'h0000012A);
		wr(OFS_STATE, 32'h00000005);
		rd(OFS_STATE, 32'h00000005);
		chk(32'(resume_pin_en_q), 32'h1);
		wr(OFS_STATE, 32'h00000004);
		rd(OFS_STATE, 32'h00000005);
		host.resume();
		rd(OFS_STATE, 32'h0000000D);
		wr(OFS_STATE, 32'h00000017);
		rd(OFS_STATE, 32'h0000001F);
		chk(32'(kstate_drive_q), 32'h1);
		wr(OFS_STATE, 32'h0000000D);
		rd(OFS_STATE, 32'h00000005);
		wr(OFS_STATE, 32'h00000010);
		host.resume();
		rd(OFS_STATE, 32'h00000011);
		chk(32'(kstate_drive_q), 32'h0);
		host.bus_reset();
		@(negedge ref_clk);
		chk(32'({addressed_state_q, function_address_q}), 32'h0);
	endtask : t_state
	task t_irq();
		for (int i = 0; i < 14; i++) begin
			wr(OFS_IDR, 32'h00003FFF);
			wr(OFS_IER, 32'h1 << i);
			rd(OFS_IMR, (32'h1 << i) & 32'(IRQ_VALID));
		end
		wr(OFS_IER, 32'h0);
		rd(OFS_IMR, 32'h00002000);
		wr(OFS_IER, 32'hFFFFFFFF);
		wr(OFS_IDR, 32'h00000001);
		rd(OFS_IMR, 32'h00002F3E);
		@(posedge ref_clk) irq_status <= 14'h0001;
		repeat (2) @(negedge ref_clk);
		chk(32'(usb_irq_q), 32'h0);
		@(posedge ref_clk) irq_status <= 14'h0002;
		repeat (2) @(negedge ref_clk);
		chk(32'(usb_irq_q), 32'h1);
		wr(OFS_IDR, 32'hFFFFFFFF);
		@(negedge ref_clk);
		chk(32'(usb_irq_q), 32'h0);
		@(posedge ref_clk) irq_status <= 14'h0;
		rd(8'h24, 32'h0);
	endtask : t_irq
	// main sequence, with a second reset in mid-run
	initial begin
		rst = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		irq_status = 14'h0;
		t_reset();
		t_frame();
		t_faddr();
		t_state();
		t_irq();
		t_reset();
		t_frame();
		give_verdict();
	end
endmodule : usb_device_global_state_regs_tb_top
`default_nettype wire
